// ---- core/brbc_regs.sv ----
// Bus release and bus control registers with the external cycle sequencer they steer.
// What this block does
// - The release register resets to fe, or ee in modes 3 and 4, and survives soft standby.
// - A zero in an upper address enable bit turns port A pin 4, 5 or 6 into address 23, 22, 21.
// - Outside modes 3, 4 and 5 writes to the address 23 to 21 enables are ignored.
// - The address 20 enable drives pin 7 when zero, resets by mode and is writable in mode 5.
// - Bits 3 to 1 of the release register ignore writes and read as one.
// - With release disabled the bus is never handed over and the release pins are port pins.
// - The bus control register resets to c6 and survives soft standby.
// - One idle state separates back-to-back reads of different areas when enabled.
// - One idle state separates a read from a following write when enabled.
// - Bit 2 of the bus control register always reads as one.
// - The division select acts only in modes 3 to 5; when one all areas are 2 Mbytes.
// - With the wait pin enabled an asserted wait input stretches the external cycle.
`timescale 1ns/1ps
module brbc_regs
	import brbc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hw_standby,
	input wire logic [2:0] mode,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic cyc_valid,
	input wire brbc_req_t cyc_req,
	input wire logic [15:0] cyc_wdata,
	output logic cyc_ready,
	output logic cyc_done,
	output logic [15:0] cyc_rdata,
	output logic [23:0] ext_addr,
	output logic [15:0] ext_data_out,
	output logic ext_data_oe,
	input wire logic [15:0] ext_data_in,
	output logic ext_rd_n,
	output logic ext_wr_n,
	output logic ext_bus_oe,
	input wire logic wait_in_n,
	input wire logic bus_request_in_n,
	output logic bus_ack_n,
	output logic porta_pin4_is_addr,
	output logic porta_pin5_is_addr,
	output logic porta_pin6_is_addr,
	output logic porta_pin7_is_addr,
	output logic release_pins_are_port,
	output logic wait_pin_is_port
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [2:0] mode_q;
	logic [7:0] bus_release_control;
	logic [7:0] bus_control;
	logic wr_release;
	logic wr_control;

	assign wr_release = reg_wr && (reg_addr == BRBC_IDX_RELEASE);
	assign wr_control = reg_wr && (reg_addr == BRBC_IDX_CONTROL);

	// Straps are caught during reset so a later pin glitch cannot move the map.
	always_ff @(posedge core_clk) begin
		if (rst || hw_standby) begin
			mode_q <= mode;
		end
	end

	// Soft standby has no port here, so nothing but reset and hardware standby clears state.
	always_ff @(posedge core_clk) begin
		if (rst || hw_standby) begin
			bus_release_control <= brbc_wide_reset(mode) ? BRBC_REL_RST_WIDE :
				BRBC_REL_RST_NARROW;
		end else if (wr_release) begin
			if (brbc_large_mode(mode_q)) begin
				bus_release_control[BRBC_A23:BRBC_A21] <= reg_wdata[BRBC_A23:BRBC_A21];
			end
			if (mode_q == BRBC_MODE5) begin
				bus_release_control[BRBC_A20] <= reg_wdata[BRBC_A20];
			end
			bus_release_control[BRBC_REL_EN] <= reg_wdata[BRBC_REL_EN];
		end
	end

	// Bits 5 to 3 are stored as written; keeping them zero is left to software.
	always_ff @(posedge core_clk) begin
		if (rst || hw_standby) begin
			bus_control <= BRBC_CTL_RST;
		end else if (wr_control) begin
			bus_control <= reg_wdata | BRBC_CTL_ONES;
		end
	end

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= BRBC_RD_NONE;
		end else if (reg_rd && reg_addr == BRBC_IDX_RELEASE) begin
			reg_rdata <= bus_release_control | BRBC_REL_ONES;
		end else if (reg_rd && reg_addr == BRBC_IDX_CONTROL) begin
			reg_rdata <= bus_control | BRBC_CTL_ONES;
		end else begin
			reg_rdata <= BRBC_RD_NONE;
		end
	end

	// ------------------------------------------------------------
	// Pin function selects
	// ------------------------------------------------------------
	logic large_map;
	logic idle_between_area_reads;
	logic idle_between_read_write;
	logic wait_pin_enable;
	logic bus_release_enable;

	assign large_map = brbc_large_mode(mode_q);
	assign idle_between_area_reads = bus_control[BRBC_IDLE_AREA];
	assign idle_between_read_write = bus_control[BRBC_IDLE_RW];
	assign wait_pin_enable = bus_control[BRBC_WAIT_EN];
	assign bus_release_enable = bus_release_control[BRBC_REL_EN];

	assign porta_pin4_is_addr = large_map && !bus_release_control[BRBC_A23];
	assign porta_pin5_is_addr = large_map && !bus_release_control[BRBC_A22];
	assign porta_pin6_is_addr = large_map && !bus_release_control[BRBC_A21];
	assign porta_pin7_is_addr = !bus_release_control[BRBC_A20];
	assign release_pins_are_port = !bus_release_enable;
	assign wait_pin_is_port = !wait_pin_enable;

	// ------------------------------------------------------------
	// External cycle sequencer
	// ------------------------------------------------------------
	brbc_state_t state;
	brbc_state_t next_state;
	brbc_req_t cur;
	brbc_req_t next_req;
	logic [2:0] req_area;
	logic [2:0] cur_area;
	logic [2:0] prev_area;
	logic prev_read;
	logic release_take;
	logic accept;
	logic gap_need;
	logic stretch;
	logic cyc_end;
	logic in_cyc;

	brbc_area_decode u_area (
		.addr(cyc_req.addr),
		.mode(mode_q),
		.division(bus_control[BRBC_DIV_SEL]),
		.area(req_area)
	);

	assign release_take = bus_release_enable && !bus_request_in_n;
	assign cyc_ready = (state == BRBC_ST_IDLE) && !release_take;
	assign accept = cyc_ready && cyc_valid;
	assign stretch = wait_pin_enable && !wait_in_n;
	assign cyc_end = (state == BRBC_ST_T2) && !stretch;
	assign next_req = accept ? cyc_req : cur;

	always_comb begin
		gap_need = 1'b0;
		if (prev_read && !cyc_req.write && idle_between_area_reads
			&& req_area != prev_area) begin
			gap_need = 1'b1;
		end
		if (prev_read && cyc_req.write && idle_between_read_write) begin
			gap_need = 1'b1;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			BRBC_ST_IDLE: begin
				if (release_take) begin
					next_state = BRBC_ST_REL;
				end else if (cyc_valid) begin
					next_state = gap_need ? BRBC_ST_GAP : BRBC_ST_T1;
				end
			end
			BRBC_ST_GAP: begin
				next_state = BRBC_ST_T1;
			end
			BRBC_ST_T1: begin
				next_state = BRBC_ST_T2;
			end
			BRBC_ST_T2: begin
				if (!stretch) begin
					next_state = BRBC_ST_IDLE;
				end
			end
			BRBC_ST_REL: begin
				if (bus_request_in_n) begin
					next_state = BRBC_ST_IDLE;
				end
			end
			default: begin
				next_state = BRBC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= BRBC_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cur <= '0;
			cur_area <= '0;
			ext_addr <= '0;
			ext_data_out <= '0;
		end else if (accept) begin
			cur <= cyc_req;
			cur_area <= req_area;
			ext_addr <= cyc_req.addr;
			ext_data_out <= cyc_wdata;
		end
	end

	// Any idle clock between cycles breaks the back-to-back chain.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			prev_read <= 1'b0;
			prev_area <= '0;
		end else if (cyc_end) begin
			prev_read <= !cur.write;
			prev_area <= cur_area;
		end else if (state == BRBC_ST_IDLE && !accept) begin
			prev_read <= 1'b0;
		end
	end

	assign in_cyc = (next_state == BRBC_ST_T1) || (next_state == BRBC_ST_T2);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ext_rd_n <= 1'b1;
			ext_wr_n <= 1'b1;
			ext_data_oe <= 1'b0;
			ext_bus_oe <= 1'b1;
			bus_ack_n <= 1'b1;
		end else begin
			ext_rd_n <= !(in_cyc && !next_req.write);
			ext_wr_n <= !(in_cyc && next_req.write);
			ext_data_oe <= in_cyc && next_req.write;
			ext_bus_oe <= next_state != BRBC_ST_REL;
			bus_ack_n <= next_state != BRBC_ST_REL;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cyc_done <= 1'b0;
			cyc_rdata <= '0;
		end else begin
			cyc_done <= cyc_end;
			if (cyc_end && !cur.write) begin
				cyc_rdata <= ext_data_in;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	release_reset_a: assert property ($past(rst) |-> bus_release_control ==
		(brbc_wide_reset($past(mode)) ? BRBC_REL_RST_WIDE : BRBC_REL_RST_NARROW))
		else $error("release register reset value wrong");
	control_reset_a: assert property ($past(rst) |-> bus_control == BRBC_CTL_RST)
		else $error("control register reset value wrong");
	addr_lock_a: assert property (wr_release && !large_map && !hw_standby |=>
		$stable(bus_release_control[BRBC_A23:BRBC_A21]))
		else $error("upper address enables changed outside large modes");
	a20_lock_a: assert property (wr_release && mode_q != BRBC_MODE5 && !hw_standby |=>
		$stable(bus_release_control[BRBC_A20]))
		else $error("address 20 enable changed outside mode 5");
	pin_select_a: assert property (wr_release && large_map && !hw_standby
		&& !reg_wdata[BRBC_A23] |=> porta_pin4_is_addr)
		else $error("pin 4 not switched to address output");
	fixed_ones_a: assert property (reg_rd && reg_addr == BRBC_IDX_RELEASE |=>
		reg_rdata[3:1] == 3'h7)
		else $error("reserved release bits not read as one");
	ctl_bit2_a: assert property (reg_rd && reg_addr == BRBC_IDX_CONTROL |=>
		reg_rdata[2])
		else $error("control bit 2 not read as one");
	no_release_a: assert property (state == BRBC_ST_IDLE && !bus_release_enable |=>
		state != BRBC_ST_REL)
		else $error("bus released while release disabled");
	release_ack_a: assert property (state == BRBC_ST_REL && !bus_request_in_n |=>
		!bus_ack_n && !ext_bus_oe)
		else $error("released bus not acknowledged or still driven");
	read_gap_a: assert property (accept && gap_need |=> state == BRBC_ST_GAP ##1
		state == BRBC_ST_T1)
		else $error("idle state not inserted");
	rw_gap_a: assert property (accept && cyc_req.write && prev_read
		&& idle_between_read_write |=> state == BRBC_ST_GAP)
		else $error("read to write idle state missing");
	wait_hold_a: assert property (state == BRBC_ST_T2 && stretch |=>
		state == BRBC_ST_T2 && !cyc_done)
		else $error("cycle ended while wait asserted");

	release_seen_c: cover property (state == BRBC_ST_IDLE ##1 state == BRBC_ST_REL);
	gap_seen_c: cover property (state == BRBC_ST_GAP);
	wait_seen_c: cover property (state == BRBC_ST_T2 && stretch);
	write_seen_c: cover property (cyc_done && cur.write);

endmodule // brbc_regs

// ---- core/brbc_pkg.sv ----
// Constants, types and helper functions shared by the bus release and bus control block.
package brbc_pkg;

	// ------------------------------------------------------------
	// Register map and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] BRBC_IDX_RELEASE = 8'h00;
	localparam logic [7:0] BRBC_IDX_CONTROL = 8'h01;
	localparam logic [7:0] BRBC_RD_NONE = 8'h00;
	localparam logic [7:0] BRBC_REL_RST_NARROW = 8'hfe;
	localparam logic [7:0] BRBC_REL_RST_WIDE = 8'hee;
	localparam logic [7:0] BRBC_CTL_RST = 8'hc6;
	localparam logic [7:0] BRBC_REL_ONES = 8'h0e;
	localparam logic [7:0] BRBC_CTL_ONES = 8'h04;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BRBC_A23 = 7;
	localparam int BRBC_A22 = 6;
	localparam int BRBC_A21 = 5;
	localparam int BRBC_A20 = 4;
	localparam int BRBC_REL_EN = 0;
	localparam int BRBC_IDLE_AREA = 7;
	localparam int BRBC_IDLE_RW = 6;
	localparam int BRBC_DIV_SEL = 1;
	localparam int BRBC_WAIT_EN = 0;

	// ------------------------------------------------------------
	// Operating modes and area map
	// ------------------------------------------------------------
	localparam logic [2:0] BRBC_MODE1 = 3'h1;
	localparam logic [2:0] BRBC_MODE2 = 3'h2;
	localparam logic [2:0] BRBC_MODE3 = 3'h3;
	localparam logic [2:0] BRBC_MODE4 = 3'h4;
	localparam logic [2:0] BRBC_MODE5 = 3'h5;
	localparam int BRBC_SMALL_MSB = 19;
	localparam int BRBC_LARGE_MSB = 23;
	localparam logic [23:0] BRBC_AREA2_BASE = 24'h400000;
	localparam logic [23:0] BRBC_AREA3_BASE = 24'hc00000;
	localparam logic [23:0] BRBC_AREA4_BASE = 24'he00000;
	localparam logic [23:0] BRBC_AREA5_BASE = 24'hff90ea;
	localparam logic [23:0] BRBC_AREA6_BASE = 24'hffa0ea;
	localparam logic [23:0] BRBC_AREA7_BASE = 24'hffffea;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		BRBC_ST_IDLE = 3'b000,
		BRBC_ST_GAP = 3'b001,
		BRBC_ST_T1 = 3'b010,
		BRBC_ST_T2 = 3'b011,
		BRBC_ST_REL = 3'b100
	} brbc_state_t;

	typedef struct packed {
		logic write;
		logic [23:0] addr;
	} brbc_req_t;

	// ------------------------------------------------------------
	// Mode helpers
	// ------------------------------------------------------------
	function automatic logic brbc_large_mode(input logic [2:0] m);
		return (m == BRBC_MODE3) || (m == BRBC_MODE4) || (m == BRBC_MODE5);
	endfunction

	function automatic logic brbc_wide_reset(input logic [2:0] m);
		return (m == BRBC_MODE3) || (m == BRBC_MODE4);
	endfunction

endpackage

// ---- core/brbc_area_decode.sv ----
// Area number decoder for an external address under the current mode and division.
`timescale 1ns/1ps
module brbc_area_decode
	import brbc_pkg::*;
(
	input wire logic [23:0] addr,
	input wire logic [2:0] mode,
	input wire logic division,
	output logic [2:0] area
);

	always_comb begin
		if (mode == BRBC_MODE1 || mode == BRBC_MODE2) begin
			area = addr[BRBC_SMALL_MSB -: 3];
		end else if (!brbc_large_mode(mode) || division) begin
			area = addr[BRBC_LARGE_MSB -: 3];
		end else if (addr < BRBC_AREA2_BASE) begin
			area = addr[BRBC_LARGE_MSB -: 3];
		end else if (addr < BRBC_AREA3_BASE) begin
			area = 3'h2;
		end else if (addr < BRBC_AREA4_BASE) begin
			area = 3'h3;
		end else if (addr < BRBC_AREA5_BASE) begin
			area = 3'h4;
		end else if (addr < BRBC_AREA6_BASE) begin
			area = 3'h5;
		end else if (addr < BRBC_AREA7_BASE) begin
			area = 3'h6;
		end else begin
			area = 3'h7;
		end
	end

endmodule // brbc_area_decode

// ---- tb/brbc_ext_partner.sv ----
// Model of the external memory and the external bus master beside the block.
`timescale 1ns/1ps
module brbc_ext_partner (
	input wire logic core_clk,
	input wire logic [23:0] ext_addr,
	input wire logic [15:0] ext_data_out,
	input wire logic ext_data_oe,
	input wire logic ext_rd_n,
	input wire logic ext_wr_n,
	input wire logic want_bus,
	input wire logic [3:0] wait_len,
	output logic [15:0] ext_data_in,
	output logic wait_in_n,
	output logic bus_request_in_n,
	output logic [15:0] last_wdata
);
	// ------------------------------------------------------------
	// Memory, wait source and requesting master
	// ------------------------------------------------------------
	logic [15:0] junk = 16'h0f0f;
	logic [3:0] wait_cnt = 4'h0;
	logic was_active = 1'b0;
	logic active;

	// Outside a read the data lines change every cycle, so stale data never passes.
	assign ext_data_in = ext_rd_n ? junk : (ext_addr[15:0] ^ 16'h5a5a);
	assign active = !(ext_rd_n && ext_wr_n);
	assign wait_in_n = (wait_cnt == 4'h0);
	// The master holds its request until the bench withdraws it.
	assign bus_request_in_n = !want_bus;

	always @(posedge core_clk) begin
		junk <= ~junk;
		was_active <= active;
		if (active && !was_active) begin
			wait_cnt <= wait_len;
		end else if (wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end
		if (!ext_wr_n && ext_data_oe) begin
			last_wdata <= ext_data_out;
		end
	end
endmodule // brbc_ext_partner

// ---- tb/testbench.sv ----
// Self-checking bench for the bus release and bus control registers.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value at %0t got %h expected %h", $time, (g), (e)); end end
module testbench
	import brbc_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic hw_standby = 1'b0;
	logic [2:0] mode = 3'h1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic cyc_valid = 1'b0;
	brbc_req_t cyc_req = '0;
	logic [15:0] cyc_wdata = 16'h0000;
	logic want_bus = 1'b0;
	logic [3:0] wait_len = 4'h0;
	logic [7:0] reg_rdata;
	logic cyc_ready, cyc_done, ext_data_oe, ext_rd_n, ext_wr_n, ext_bus_oe;
	logic [15:0] cyc_rdata, ext_data_out, ext_data_in, last_wdata;
	logic [23:0] ext_addr;
	logic wait_in_n, bus_request_in_n, bus_ack_n, release_pins_are_port, wait_pin_is_port;
	logic porta_pin4_is_addr, porta_pin5_is_addr, porta_pin6_is_addr, porta_pin7_is_addr;
	logic w_rst, l_big;
	int miscompares = 0;
	int comparisons = 0;

	always #4 core_clk = ~core_clk;

	brbc_regs i_brbc_regs (
		.core_clk, .rst, .hw_standby, .mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .cyc_valid, .cyc_req, .cyc_wdata, .cyc_ready, .cyc_done, .cyc_rdata,
		.ext_addr, .ext_data_out, .ext_data_oe, .ext_data_in, .ext_rd_n, .ext_wr_n,
		.ext_bus_oe, .wait_in_n, .bus_request_in_n, .bus_ack_n, .porta_pin4_is_addr,
		.porta_pin5_is_addr, .porta_pin6_is_addr, .porta_pin7_is_addr,
		.release_pins_are_port, .wait_pin_is_port
	);

	brbc_ext_partner i_brbc_ext_partner (
		.core_clk, .ext_addr, .ext_data_out, .ext_data_oe, .ext_rd_n, .ext_wr_n,
		.want_bus, .wait_len, .ext_data_in, .wait_in_n, .bus_request_in_n, .last_wdata
	);

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
		@(posedge core_clk);
	endtask

	// Two external cycles offered back to back; e counts edges from the first
	// take to the cycle in which the second one completes.
	task automatic row(input logic [2:0] m, input logic [7:0] c, input logic [3:0] w,
		input logic aw, input logic [23:0] aa, input logic bw, input logic [23:0] ba,
		input int e);
		int n;
		n = 0;
		mode <= m;
		hw_standby <= 1'b1;
		@(posedge core_clk);
		hw_standby <= 1'b0;
		wr(8'h01, c);
		wait_len <= w;
		cyc_req <= {aw, aa};
		cyc_wdata <= ~aa[15:0];
		cyc_valid <= 1'b1;
		#1;
		while (cyc_ready !== 1'b1 && n < 40) begin
			@(posedge core_clk);
			#1 n++;
		end
		@(posedge core_clk);
		n = 0;
		cyc_req <= {bw, ba};
		cyc_wdata <= ~ba[15:0];
		do begin
			@(posedge core_clk);
			#1 n++;
		end while (cyc_ready !== 1'b1 && n < 40);
		@(posedge core_clk);
		n++;
		cyc_valid <= 1'b0;
		do begin
			@(posedge core_clk);
			#1 n++;
		end while (cyc_done !== 1'b1 && n < 40);
		`CHK(n, e)
		if (!bw) `CHK(cyc_rdata, ba[15:0] ^ 16'h5a5a)
		else `CHK(last_wdata, ~ba[15:0])
		@(posedge core_clk);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(8'h00, 8'hfe);
		#1 `CHK(reg_rdata, 8'h00)
		@(posedge core_clk);
		rd(8'h02, 8'h00);
		wr(8'h02, 8'hff);
		rd(8'h01, 8'hc6);
		for (int m = 1; m < 8; m++) begin
			mode <= 3'(m);
			hw_standby <= 1'b1;
			@(posedge core_clk);
			hw_standby <= 1'b0;
			w_rst = (m == 3 || m == 4);
			l_big = (m >= 3 && m <= 5);
			rd(8'h00, w_rst ? 8'hee : 8'hfe);
			rd(8'h01, 8'hc6);
			wr(8'h00, 8'h00);
			rd(8'h00, {{3{~l_big}}, (m == 5) ? 1'b0 : ~w_rst, 4'he});
			#1 `CHK(porta_pin4_is_addr, l_big)
			`CHK(porta_pin5_is_addr, l_big)
			`CHK(porta_pin6_is_addr, l_big)
			`CHK(porta_pin7_is_addr, m == 5 || w_rst)
			`CHK(wait_pin_is_port, 1'b1)
			@(posedge core_clk);
			wr(8'h01, 8'h01);
			rd(8'h01, 8'h05);
			#1 `CHK(wait_pin_is_port, 1'b0)
			@(posedge core_clk);
		end
		row(3'h5, 8'hc6, 4'h0, 1'b0, 24'h000010, 1'b0, 24'h200010, 6);
		row(3'h5, 8'hc6, 4'h0, 1'b0, 24'h000010, 1'b0, 24'h000020, 5);
		row(3'h5, 8'hc6, 4'h0, 1'b0, 24'h000010, 1'b1, 24'h000020, 6);
		row(3'h5, 8'hc6, 4'h0, 1'b1, 24'h000010, 1'b0, 24'h200020, 5);
		row(3'h5, 8'h06, 4'h0, 1'b0, 24'h000010, 1'b0, 24'h200010, 5);
		row(3'h5, 8'h06, 4'h0, 1'b0, 24'h000010, 1'b1, 24'h000020, 5);
		row(3'h5, 8'h07, 4'h2, 1'b0, 24'h000010, 1'b0, 24'h000020, 9);
		row(3'h5, 8'h06, 4'h2, 1'b0, 24'h000010, 1'b0, 24'h000020, 5);
		row(3'h5, 8'hc6, 4'h0, 1'b0, 24'h400010, 1'b0, 24'h900010, 6);
		row(3'h5, 8'hc4, 4'h0, 1'b0, 24'h400010, 1'b0, 24'h900010, 5);
		row(3'h5, 8'hc4, 4'h0, 1'b0, 24'hff90e9, 1'b0, 24'hff90ea, 6);
		row(3'h5, 8'hc6, 4'h0, 1'b0, 24'hff90e9, 1'b0, 24'hff90ea, 5);
		row(3'h1, 8'hc4, 4'h0, 1'b0, 24'h000010, 1'b0, 24'h020010, 6);
		row(3'h1, 8'hc6, 4'h0, 1'b0, 24'h400010, 1'b0, 24'h900010, 5);
		want_bus <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1 `CHK(bus_ack_n, 1'b1)
		`CHK(release_pins_are_port, 1'b1)
		@(posedge core_clk);
		wr(8'h00, 8'h01);
		repeat (3) @(posedge core_clk);
		#1 `CHK(bus_ack_n, 1'b0)
		`CHK(ext_bus_oe, 1'b0)
		`CHK(cyc_ready, 1'b0)
		`CHK(release_pins_are_port, 1'b0)
		@(posedge core_clk);
		want_bus <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1 `CHK(bus_ack_n, 1'b1)
		`CHK(ext_bus_oe, 1'b1)
		report_and_stop();
	end

	// A hang is cut short well past the few hundred cycles the tests need.
	initial begin
		repeat (5000) @(posedge core_clk);
		miscompares++;
		report_and_stop();
	end
endmodule // testbench
